// ---- design/rxc_pkg.sv ----
// shared constants for the receive control register bank and its host
// Functional notes
// - receive-start enters receive mode, then self-clears
// - firmware never clears or re-sets pending start; the host writes start as zero while pending, which the device ignores
// - reserved control bit always written as zero
// - never enable not-empty and half-full together
// - flags live regardless; interrupt on flag and enable
// - auto gain drives amplifier, else manual bit
// - attenuator bit enables attenuator; only manual-off use
// - quick turnaround offsets; low sideband inverts data
// - overwrite allowed: new packet replaces, flag raised
// - overwrite barred: start ignored until buffer empty
// - interleave stores eight data bytes with valids
// - overwrite flag cleared by status write
// - start-of-packet flag set on each accepted start
// - full flag tracks buffer full
// - half flag at eight or more bytes
// - not-empty flag tracks one or more bytes
// - firmware rechecks count and drains leftover bytes
// - buffer error on bad read/write; cleared by start
// - done after acknowledge or valid packet; read clears
// - firmware rereads status only when error clear
// - receive error on bad packet or drop
// - receive error clears on status read
package rxc_pkg;
	// device register offsets
	localparam logic [7:0] RXC_CTRL_ADDR = 8'h05;
	localparam logic [7:0] RXC_CFG_ADDR = 8'h06;
	localparam logic [7:0] RXC_STAT_ADDR = 8'h07;
	// reset values
	localparam logic [7:0] RXC_CTRL_RST = 8'h07;
	localparam logic [7:0] RXC_CFG_RST = 8'h92;
	localparam logic [7:0] RXC_STAT_RST = 8'h00;
	// control fields
	localparam int RXC_CTRL_GO = 7;
	localparam int RXC_CTRL_RSVD = 6;
	localparam int RXC_CTRL_HALF_EN = 4;
	localparam int RXC_CTRL_NEMP_EN = 3;
	localparam logic [7:0] RXC_CTRL_EN_MASK = 8'h3f;
	// configuration fields
	localparam int RXC_CFG_AGC = 7;
	localparam int RXC_CFG_LNA = 6;
	localparam int RXC_CFG_ATT = 5;
	localparam int RXC_CFG_SIDE = 4;
	localparam int RXC_CFG_FAST = 3;
	localparam int RXC_CFG_OW = 1;
	localparam int RXC_CFG_VLD = 0;
	localparam logic [7:0] RXC_CFG_MASK = 8'hfb;
	// status fields
	localparam int RXC_ST_OW = 7;
	localparam int RXC_ST_SOP = 6;
	localparam int RXC_ST_FULL = 5;
	localparam int RXC_ST_HALF = 4;
	localparam int RXC_ST_NEMP = 3;
	localparam int RXC_ST_BERR = 2;
	localparam int RXC_ST_DONE = 1;
	localparam int RXC_ST_ERR = 0;
	// receive buffer shape
	localparam int RXC_BUF_DEPTH = 16;
	localparam int RXC_LVL_W = 5;
	localparam logic [4:0] RXC_LVL_FULL = 5'h10;
	localparam logic [4:0] RXC_LVL_HALF = 5'h08;
	// host register byte offsets on wishbone
	localparam logic [7:0] RXC_H_ADDR = 8'h00;
	localparam logic [7:0] RXC_H_WDATA = 8'h04;
	localparam logic [7:0] RXC_H_CMD = 8'h08;
	localparam logic [7:0] RXC_H_STAT = 8'h0c;
	localparam int RXC_CMD_WR = 0;
	localparam int RXC_CMD_RD = 1;
endpackage

// ---- design/rxc_if.sv ----
// register access link between the host controller and the receive control device
`timescale 1ns/1ps
interface rxc_if;
	logic req; // one-cycle request pulse from host
	logic we; // request is a write
	logic [7:0] addr; // register offset
	logic [7:0] wdata; // write data
	logic [7:0] rdata; // read data, valid with ack
	logic ack; // one-cycle answer pulse from device
	logic irq; // interrupt level from device
	modport dev (input req, input we, input addr, input wdata, output rdata, output ack,
		output irq);
	modport host (output req, output we, output addr, output wdata, input rdata,
		input ack, input irq);
endinterface

// ---- design/rxc_buf.sv ----
// sixteen-entry receive byte buffer with flush and level
`timescale 1ns/1ps
module rxc_buf
	import rxc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic push_i,
	input wire logic [7:0] push_data_i,
	input wire logic pop_i,
	input wire logic flush_i,
	output logic [7:0] pop_data_o,
	output logic [4:0] level_o
);
	logic [7:0] mem [RXC_BUF_DEPTH]; // byte storage
	logic [3:0] wr_ptr_reg; // next write slot
	logic [3:0] rd_ptr_reg; // next read slot
	logic do_push; // push that fits
	logic do_pop; // pop that has data

	// overflowing pushes and empty pops are dropped; the caller flags them
	assign do_push = push_i && (level_o != RXC_LVL_FULL);
	assign do_pop = pop_i && (level_o != 5'h00);

	// storage has no reset; pointers, level and read data do
	always_ff @(posedge clk_i)
	begin
		if (do_push && !flush_i)
		begin
			mem[wr_ptr_reg] <= push_data_i;
		end
	end

	// pointers and level; flush wins over everything
	always_ff @(posedge clk_i)
	begin
		if (rst_i || flush_i)
		begin
			wr_ptr_reg <= 4'h0;
			rd_ptr_reg <= 4'h0;
			level_o <= 5'h00;
		end
		else
		begin
			if (do_push)
			begin
				wr_ptr_reg <= wr_ptr_reg + 4'h1;
			end
			if (do_pop)
			begin
				rd_ptr_reg <= rd_ptr_reg + 4'h1;
			end
			if (do_push && !do_pop)
			begin
				level_o <= level_o + 5'h01;
			end
			else if (do_pop && !do_push)
			begin
				level_o <= level_o - 5'h01;
			end
		end
	end

	// registered read data, last popped byte held
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pop_data_o <= 8'h00;
		end
		else if (do_pop)
		begin
			pop_data_o <= mem[rd_ptr_reg];
		end
	end
endmodule

// ---- design/rxc_dev.sv ----
// receive control device: registers, flags, packet acceptance and buffer
`timescale 1ns/1ps
module rxc_dev
	import rxc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	rxc_if.dev bus,
	input wire logic sop_i,
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_i,
	input wire logic [7:0] valid_bits_i,
	input wire logic pkt_ok_i,
	input wire logic pkt_err_i,
	input wire logic ack_sent_i,
	input wire logic xact_mode_i,
	input wire logic agc_lna_i,
	input wire logic buf_pop_i,
	output logic [7:0] buf_data_o,
	output logic rx_mode_o,
	output logic lna_on_o,
	output logic atten_o,
	output logic freq_high_o,
	output logic fast_turn_o,
	output logic invert_data_o
);
	typedef enum logic {RXC_IDLE, RXC_RUN} rxc_state_e;

	rxc_state_e state_reg; // idle or receiving
	logic [7:0] ctrl_reg; // control: start and enables
	logic [7:0] cfg_reg; // configuration
	logic ow_flag_reg; // overwrite flag
	logic sop_flag_reg; // start-of-packet flag
	logic berr_flag_reg; // buffer error flag
	logic done_flag_reg; // receive complete flag
	logic err_flag_reg; // receive error flag
	logic active_reg; // a packet is being loaded
	logic vld_pend_reg; // valid byte waiting to follow its data byte
	logic [7:0] vld_byte_reg; // that valid byte
	logic [7:0] rdata_reg; // read answer
	logic ack_reg; // answer pulse
	logic irq_reg; // interrupt level
	logic [4:0] level; // buffer occupancy
	logic [7:0] status; // live status image
	logic wr_req; // register write this cycle
	logic rd_stat; // status read this cycle
	logic wr_stat; // status write this cycle
	logic empty; // buffer empty
	logic full; // buffer full
	logic sop_take; // start that loads a packet
	logic sop_drop; // start refused for occupancy
	logic flush; // discard old contents
	logic push; // byte into buffer
	logic [7:0] push_data; // what goes in
	logic [7:0] rx_byte; // received byte after inversion
	logic done_ev; // completion event
	logic err_ev; // error event
	logic invert; // low sideband under quick turnaround

	assign wr_req = bus.req && bus.we;
	assign rd_stat = bus.req && !bus.we && (bus.addr == RXC_STAT_ADDR);
	assign wr_stat = wr_req && (bus.addr == RXC_STAT_ADDR);
	assign empty = (level == 5'h00);
	assign full = (level == RXC_LVL_FULL);
	assign invert = cfg_reg[RXC_CFG_FAST] && !cfg_reg[RXC_CFG_SIDE];
	assign rx_byte = invert ? ~byte_i : byte_i;

	// a start is taken only while receiving; a non-empty buffer blocks it unless overwriting
	assign sop_take = sop_i && (state_reg == RXC_RUN) && (empty || cfg_reg[RXC_CFG_OW]);
	assign sop_drop = sop_i && (state_reg == RXC_RUN) && !empty && !cfg_reg[RXC_CFG_OW];
	assign flush = sop_take && !empty;

	// interleave pushes the valid byte in the cycle after its data byte,
	// so the radio must leave a gap cycle between bytes in that mode
	assign push = (active_reg && byte_valid_i) || vld_pend_reg;
	assign push_data = vld_pend_reg ? vld_byte_reg : rx_byte;

	// completion follows the acknowledge in transaction mode, else the good packet
	assign done_ev = active_reg && (xact_mode_i ? ack_sent_i : pkt_ok_i);
	assign err_ev = (active_reg && pkt_err_i) || sop_drop;

	// live flags: buffer levels are read straight from the occupancy
	always_comb
	begin
		status = 8'h00;
		status[RXC_ST_OW] = ow_flag_reg;
		status[RXC_ST_SOP] = sop_flag_reg;
		status[RXC_ST_FULL] = full;
		status[RXC_ST_HALF] = (level >= RXC_LVL_HALF);
		status[RXC_ST_NEMP] = !empty;
		status[RXC_ST_BERR] = berr_flag_reg;
		status[RXC_ST_DONE] = done_flag_reg;
		status[RXC_ST_ERR] = err_flag_reg;
	end

	rxc_buf u_buf (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.push_i(push),
		.push_data_i(push_data),
		.pop_i(buf_pop_i),
		.flush_i(flush),
		.pop_data_o(buf_data_o),
		.level_o(level)
	);

	// receive sequencing; start bit self-clears when the packet ends
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= RXC_IDLE;
			active_reg <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				RXC_IDLE:
				begin
					if (ctrl_reg[RXC_CTRL_GO])
					begin
						state_reg <= RXC_RUN;
					end
				end
				RXC_RUN:
				begin
					if (done_ev || (active_reg && pkt_err_i))
					begin
						state_reg <= RXC_IDLE;
						active_reg <= 1'b0;
					end
					else if (sop_take)
					begin
						active_reg <= 1'b1;
					end
				end
			endcase
		end
	end

	// valid byte tracking for interleaved storage
	always_ff @(posedge clk_i)
	begin
		if (rst_i || flush)
		begin
			vld_pend_reg <= 1'b0;
			vld_byte_reg <= 8'h00;
		end
		else
		begin
			vld_pend_reg <= active_reg && byte_valid_i && cfg_reg[RXC_CFG_VLD];
			vld_byte_reg <= valid_bits_i;
		end
	end

	// control register; zero written to start has no effect
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_reg <= RXC_CTRL_RST;
		end
		else if (wr_req && (bus.addr == RXC_CTRL_ADDR))
		begin
			ctrl_reg[5:0] <= bus.wdata[5:0] & RXC_CTRL_EN_MASK[5:0];
			ctrl_reg[RXC_CTRL_RSVD] <= 1'b0;
			// a packet end in the write cycle still clears start, else receive would rerun
			ctrl_reg[RXC_CTRL_GO] <= (bus.wdata[RXC_CTRL_GO] || ctrl_reg[RXC_CTRL_GO])
				&& !(done_ev || (active_reg && pkt_err_i));
		end
		else if (state_reg == RXC_RUN && (done_ev || (active_reg && pkt_err_i)))
		begin
			ctrl_reg[RXC_CTRL_GO] <= 1'b0;
		end
	end

	// configuration register; unused bit reads zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg_reg <= RXC_CFG_RST;
		end
		else if (wr_req && (bus.addr == RXC_CFG_ADDR))
		begin
			cfg_reg <= bus.wdata & RXC_CFG_MASK;
		end
	end

	// sticky flags; a setting event in the clearing cycle wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ow_flag_reg <= RXC_STAT_RST[RXC_ST_OW];
			sop_flag_reg <= RXC_STAT_RST[RXC_ST_SOP];
			berr_flag_reg <= RXC_STAT_RST[RXC_ST_BERR];
			done_flag_reg <= RXC_STAT_RST[RXC_ST_DONE];
			err_flag_reg <= RXC_STAT_RST[RXC_ST_ERR];
		end
		else
		begin
			// any status write clears, a new overwrite sets again
			ow_flag_reg <= flush || (ow_flag_reg && !wr_stat);
			// start-of-packet flag drops on a status read
			sop_flag_reg <= sop_take || (sop_flag_reg && !rd_stat);
			// bad read or overrun sets; accepted start while running clears
			if ((buf_pop_i && empty) || (push && full))
			begin
				berr_flag_reg <= 1'b1;
			end
			else if (sop_take)
			begin
				berr_flag_reg <= 1'b0;
			end
			done_flag_reg <= done_ev || (done_flag_reg && !rd_stat);
			err_flag_reg <= err_ev || (err_flag_reg && !rd_stat);
		end
	end

	// register answer one cycle after the request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end
		else
		begin
			ack_reg <= bus.req;
			if (bus.req && !bus.we)
			begin
				unique case (bus.addr)
					RXC_CTRL_ADDR: rdata_reg <= ctrl_reg;
					RXC_CFG_ADDR: rdata_reg <= cfg_reg;
					RXC_STAT_ADDR: rdata_reg <= status;
					default: rdata_reg <= 8'h00;
				endcase
			end
		end
	end

	// interrupt: enables pair bit for bit; overwrite is armed by the overwrite option
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_reg <= 1'b0;
		end
		else
		begin
			irq_reg <= (|(status[5:0] & ctrl_reg[5:0]))
				|| (ow_flag_reg && cfg_reg[RXC_CFG_OW]);
		end
	end

	// analog path controls, registered
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_mode_o <= 1'b0;
			lna_on_o <= 1'b0;
			atten_o <= 1'b0;
			freq_high_o <= 1'b0;
			fast_turn_o <= 1'b0;
			invert_data_o <= 1'b0;
		end
		else
		begin
			// receive mode also starts oscillator and synthesizer
			rx_mode_o <= (state_reg == RXC_RUN);
			lna_on_o <= cfg_reg[RXC_CFG_AGC] ? agc_lna_i : cfg_reg[RXC_CFG_LNA];
			atten_o <= cfg_reg[RXC_CFG_ATT];
			// same bit picks channel side or injection side depending on mode
			freq_high_o <= cfg_reg[RXC_CFG_SIDE];
			fast_turn_o <= cfg_reg[RXC_CFG_FAST];
			invert_data_o <= invert;
		end
	end

	assign bus.rdata = rdata_reg;
	assign bus.ack = ack_reg;
	assign bus.irq = irq_reg;
endmodule

// ---- design/rxc_host.sv ----
// host controller: wishbone slave that issues register accesses to the device
`timescale 1ns/1ps
module rxc_host
	import rxc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	rxc_if.host bus
);
	typedef enum logic [1:0] {RXH_IDLE, RXH_REQ, RXH_WAIT} rxh_state_e;

	rxh_state_e state_reg; // access sequencer
	logic [7:0] addr_reg; // device offset to use
	logic [7:0] wdata_reg; // data to write
	logic [7:0] rdata_reg; // last read answer
	logic we_reg; // current access is a write
	logic [7:0] out_data_reg; // data placed on the link
	logic go_sent_reg; // start issued and not yet seen cleared
	logic wb_hit; // fresh wishbone access
	logic cmd_wr; // command write on lane 0
	logic [7:0] fixed; // write data after guarding

	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign cmd_wr = wb_hit && wb_we_i && wb_sel_i[0] && (wb_adr_i == RXC_H_CMD);

	// guards applied to writes before they reach the device
	always_comb
	begin
		fixed = wdata_reg;
		if (addr_reg == RXC_CTRL_ADDR)
		begin
			fixed[RXC_CTRL_RSVD] = 1'b0;
			// a pending start is never set again; clearing is harmless in the device
			if (go_sent_reg)
			begin
				fixed[RXC_CTRL_GO] = 1'b0;
			end
			// never both buffer-level enables: half-full wins
			if (fixed[RXC_CTRL_HALF_EN])
			begin
				fixed[RXC_CTRL_NEMP_EN] = 1'b0;
			end
		end
		else if (addr_reg == RXC_CFG_ADDR)
		begin
			// attenuator only with gain control off and amplifier off
			if (fixed[RXC_CFG_AGC] || fixed[RXC_CFG_LNA])
			begin
				fixed[RXC_CFG_ATT] = 1'b0;
			end
		end
	end

	// software registers on byte lane 0
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			addr_reg <= 8'h00;
			wdata_reg <= 8'h00;
		end
		else if (wb_hit && wb_we_i && wb_sel_i[0] && (state_reg == RXH_IDLE))
		begin
			if (wb_adr_i == RXC_H_ADDR)
			begin
				addr_reg <= wb_dat_i[7:0];
			end
			if (wb_adr_i == RXC_H_WDATA)
			begin
				wdata_reg <= wb_dat_i[7:0];
			end
		end
	end

	// wishbone answer one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_hit;
			unique case (wb_adr_i)
				RXC_H_ADDR: wb_dat_o <= {24'h00_0000, addr_reg};
				RXC_H_WDATA: wb_dat_o <= {24'h00_0000, wdata_reg};
				RXC_H_STAT: wb_dat_o <= {16'h0000, rdata_reg, 5'h00, go_sent_reg,
					bus.irq, (state_reg != RXH_IDLE)};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// access sequencer: commands while busy are ignored
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= RXH_IDLE;
			we_reg <= 1'b0;
			out_data_reg <= 8'h00;
			rdata_reg <= 8'h00;
		end
		else
		begin
			unique case (state_reg)
				RXH_IDLE:
				begin
					if (cmd_wr && (wb_dat_i[RXC_CMD_WR] || wb_dat_i[RXC_CMD_RD]))
					begin
						state_reg <= RXH_REQ;
						we_reg <= wb_dat_i[RXC_CMD_WR];
						out_data_reg <= fixed;
					end
				end
				RXH_REQ: state_reg <= RXH_WAIT;
				RXH_WAIT:
				begin
					if (bus.ack)
					begin
						state_reg <= RXH_IDLE;
						if (!we_reg)
						begin
							rdata_reg <= bus.rdata;
						end
					end
				end
				default: state_reg <= RXH_IDLE;
			endcase
		end
	end

	// start tracking: a read of control showing start clear releases the guard
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			go_sent_reg <= 1'b0;
		end
		else if (state_reg == RXH_REQ && we_reg && addr_reg == RXC_CTRL_ADDR
			&& out_data_reg[RXC_CTRL_GO])
		begin
			go_sent_reg <= 1'b1;
		end
		else if (state_reg == RXH_WAIT && bus.ack && !we_reg && addr_reg == RXC_CTRL_ADDR
			&& !bus.rdata[RXC_CTRL_GO])
		begin
			go_sent_reg <= 1'b0;
		end
	end

	// interrupt mirrored to the system
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_o <= 1'b0;
		end
		else
		begin
			irq_o <= bus.irq;
		end
	end

	assign bus.req = (state_reg == RXH_REQ);
	assign bus.we = we_reg;
	assign bus.addr = addr_reg;
	assign bus.wdata = out_data_reg;
endmodule

// ---- tb/rxc_link_asserts.sv ----
// concurrent checks on the register link between host controller and device
`timescale 1ns/1ps
module rxc_link_asserts
	import rxc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic ack,
	input wire logic irq
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic ctrl_wr; // control register write on the link
	logic both_en; // not-empty and half-full enables written together
	logic att_bad; // attenuator written while gain is not manually off
	logic ctrl_rd_reg; // last cycle carried a control register read
	logic go_pend_reg; // start sent, not yet seen cleared by a control read
	assign ctrl_wr = req && we && addr == RXC_CTRL_ADDR;
	assign both_en = wdata[RXC_CTRL_HALF_EN] && wdata[RXC_CTRL_NEMP_EN];
	assign att_bad = wdata[RXC_CFG_ATT] && (wdata[RXC_CFG_AGC] || wdata[RXC_CFG_LNA]);
	// track start ownership from the link alone, so host bookkeeping slips show up
	always_ff @(posedge clk_i)
	begin
		ctrl_rd_reg <= !rst_i && req && !we && addr == RXC_CTRL_ADDR;
		if (rst_i || (ack && ctrl_rd_reg && !rdata[RXC_CTRL_GO]))
			go_pend_reg <= 1'b0;
		else if (ctrl_wr && wdata[RXC_CTRL_GO])
			go_pend_reg <= 1'b1;
	end
	a_ack_next_cycle: assert property (req |=> ack)
		else $error("link request not answered in the next cycle");
	a_ack_one_pulse: assert property (ack |=> !ack)
		else $error("link answer held longer than one cycle");
	a_ack_has_cause: assert property (ack |-> $past(req))
		else $error("link answer without a request");
	a_req_spaced: assert property (req |=> !req)
		else $error("second link request while one is outstanding");
	a_start_guard: assert property (ctrl_wr && go_pend_reg |-> !wdata[RXC_CTRL_GO])
		else $error("start resent before it was seen cleared");
	a_rsvd_write_zero: assert property (ctrl_wr |-> !wdata[RXC_CTRL_RSVD])
		else $error("reserved control bit written as one");
	a_rsvd_read_zero: assert property (ack && ctrl_rd_reg |-> !rdata[RXC_CTRL_RSVD])
		else $error("reserved control bit reads as one");
	a_enables_exclusive: assert property (ctrl_wr |-> !both_en)
		else $error("not-empty and half-full enables written together");
	a_atten_guard: assert property (req && we && addr == RXC_CFG_ADDR |-> !att_bad)
		else $error("attenuator written with gain not manually off");
	a_quiet_after_reset: assert property ($fell(rst_i) |-> !irq && !ack)
		else $error("interrupt or answer active right after reset");
	c_start: cover property (ctrl_wr && wdata[RXC_CTRL_GO]);
	c_irq_rise: cover property ($rose(irq));
	c_ow_seen: cover property (ack && rdata[RXC_ST_OW]);
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the host controller and receive control device pair
`timescale 1ns/1ps
module tb;
	import rxc_pkg::*;
	// per row: cfg written, gain demand, then lna, att, high, fast, invert
	localparam logic [13:0] CT [8] = '{14'h2030, 14'h3000, 14'h1010, 14'h0020,
		14'h0808, 14'h2800, 14'h0606, 14'h0203};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack;
	logic irq_o;
	logic [4:0] ev_v = 5'h00; // sop, ok, err, ack sent, pop
	logic bv = 1'b0;
	logic [7:0] bd = 8'h00;
	logic [7:0] vb = 8'h00; // valid byte paired with bd
	logic xm = 1'b0;
	logic agl = 1'b0;
	logic [7:0] bdo;
	logic rxm, lna, attenuator_enable, fh, ft, inv;
	int fails = 0;
	int num_checks = 0;
	rxc_if link();
	always #2 clk_i = ~clk_i;
	rxc_host rxc_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .irq_o(irq_o), .bus(link));
	rxc_dev rxc_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(link), .sop_i(ev_v[0]),
		.byte_valid_i(bv), .byte_i(bd), .valid_bits_i(vb), .pkt_ok_i(ev_v[1]),
		.pkt_err_i(ev_v[2]), .ack_sent_i(ev_v[3]), .xact_mode_i(xm), .agc_lna_i(agl),
		.buf_pop_i(ev_v[4]), .buf_data_o(bdo), .rx_mode_o(rxm), .lna_on_o(lna),
		.atten_o(attenuator_enable), .freq_high_o(fh), .fast_turn_o(ft), .invert_data_o(inv));
	rxc_link_asserts rxc_link_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .req(link.req),
		.we(link.we), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
		.ack(link.ack), .irq(link.irq));
	task stop_test();
		if (fails == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// one classic cycle; the request stays put until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat <= {24'h0, d};
		do
			@(posedge clk_i);
		while (wb_ack !== 1'b1);
		r = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	// device access through the host; poll busy since staging writes are dropped while busy
	task dv(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		logic [31:0] t;
		if (w)
			wb(1'b1, RXC_H_WDATA, d, t);
		wb(1'b1, RXC_H_ADDR, a, t);
		wb(1'b1, RXC_H_CMD, w ? 8'h01 : 8'h02, t);
		do
			wb(1'b0, RXC_H_STAT, 8'h00, t);
		while (t[0] === 1'b1);
		r = t[15:8];
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		dv(1'b1, a, d, r);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] r;
		dv(1'b0, a, 8'h00, r);
		chk(r & m, e);
	endtask
	// single-cycle radio event pulse
	task ev(input int i);
		@(posedge clk_i);
		ev_v[i] <= 1'b1;
		@(posedge clk_i);
		ev_v[i] <= 1'b0;
	endtask
	task push(input logic [7:0] d);
		@(posedge clk_i);
		bv <= 1'b1;
		bd <= d;
		vb <= ~d;
		@(posedge clk_i);
		bv <= 1'b0;
	endtask
	// popped byte lands one cycle later, so look at it mid-cycle
	task pop(input logic [7:0] e);
		ev(4);
		@(negedge clk_i);
		chk(bdo, e);
	endtask
	task t_reset();
		logic [31:0] t;
		rd(RXC_CTRL_ADDR, 8'hff, 8'h07);
		rd(RXC_CFG_ADDR, 8'hff, RXC_CFG_RST);
		rd(RXC_STAT_ADDR, 8'hff, 8'h00);
		rd(8'h09, 8'hff, 8'h00);
		wb(1'b0, 8'h10, 8'h00, t);
		chk(t, 32'h0);
		wr(RXC_CTRL_ADDR, 8'h58);
		rd(RXC_CTRL_ADDR, 8'hff, 8'h10);
	endtask
	task t_cfg();
		for (int i = 0; i < 8; i++)
		begin
			agl <= CT[i][5];
			wr(RXC_CFG_ADDR, CT[i][13:6]);
			chk({lna, attenuator_enable, fh, ft, inv}, CT[i][4:0]);
		end
	endtask
	task t_packet();
		wr(RXC_CFG_ADDR, 8'h00);
		wr(RXC_CTRL_ADDR, 8'h8a);
		chk(rxm, 1'b1);
		ev(0);
		push(8'ha1);
		push(8'ha2);
		ev(1);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 1'b1);
		rd(RXC_STAT_ADDR, 8'hff, 8'h4a);
		rd(RXC_STAT_ADDR, 8'hff, 8'h08);
		rd(RXC_CTRL_ADDR, 8'hff, 8'h0a);
		chk(rxm, 1'b0);
		pop(8'ha1);
		pop(8'ha2);
		rd(RXC_STAT_ADDR, 8'hff, 8'h00);
		chk(irq_o, 1'b0);
	endtask
	task t_over();
		wr(RXC_CFG_ADDR, 8'h02);
		for (int i = 0; i < 2; i++)
		begin
			wr(RXC_CTRL_ADDR, 8'h80);
			ev(0);
			push(8'hb1 + 8'(i));
			ev(1);
			if (i == 0)
				rd(RXC_CTRL_ADDR, 8'hff, 8'h00);
		end
		rd(RXC_STAT_ADDR, 8'hff, 8'hca);
		wr(RXC_STAT_ADDR, 8'h80);
		rd(RXC_STAT_ADDR, 8'hff, 8'h08);
		rd(RXC_CTRL_ADDR, 8'hff, 8'h00);
		pop(8'hb2);
		wr(RXC_CFG_ADDR, 8'h00);
		wr(RXC_CTRL_ADDR, 8'h80);
		ev(0);
		push(8'hc1);
		ev(1);
		rd(RXC_CTRL_ADDR, 8'hff, 8'h00);
		wr(RXC_CTRL_ADDR, 8'h80);
		ev(0);
		rd(RXC_STAT_ADDR, 8'h89, 8'h09);
		pop(8'hc1);
		ev(0);
		ev(1);
		rd(RXC_CTRL_ADDR, 8'hff, 8'h00);
	endtask
	task t_buf();
		ev(4);
		rd(RXC_STAT_ADDR, 8'h04, 8'h04);
		wr(RXC_CFG_ADDR, 8'h02);
		wr(RXC_CTRL_ADDR, 8'h84);
		ev(0);
		rd(RXC_STAT_ADDR, 8'h04, 8'h00);
		repeat (7) push(8'h11);
		rd(RXC_STAT_ADDR, 8'h30, 8'h00);
		push(8'h11);
		rd(RXC_STAT_ADDR, 8'h30, 8'h10);
		repeat (8) push(8'h11);
		rd(RXC_STAT_ADDR, 8'h34, 8'h30);
		push(8'h11);
		rd(RXC_STAT_ADDR, 8'h34, 8'h34);
		chk(irq_o, 1'b1);
		ev(1);
		rd(RXC_CTRL_ADDR, 8'hff, 8'h04);
		pop(8'h11);
		rd(RXC_STAT_ADDR, 8'h34, 8'h14);
		wr(RXC_CTRL_ADDR, 8'h84);
		ev(0);
		rd(RXC_STAT_ADDR, 8'h3c, 8'h00);
		ev(1);
		rd(RXC_CTRL_ADDR, 8'hff, 8'h04);
	endtask
	task t_err();
		logic [7:0] r;
		logic [31:0] t;
		wr(RXC_STAT_ADDR, 8'h80);
		dv(1'b0, RXC_STAT_ADDR, 8'h00, r);
		wr(RXC_CTRL_ADDR, 8'h81);
		ev(0);
		ev(2);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 1'b1);
		wr(RXC_CTRL_ADDR, 8'h81);
		wb(1'b0, RXC_H_STAT, 8'h00, t);
		chk(t[2:1], 2'b11);
		rd(RXC_CTRL_ADDR, 8'hff, 8'h01);
		rd(RXC_STAT_ADDR, 8'h03, 8'h01);
		rd(RXC_STAT_ADDR, 8'h03, 8'h00);
		xm <= 1'b1;
		wr(RXC_CTRL_ADDR, 8'h80);
		ev(0);
		ev(1);
		rd(RXC_STAT_ADDR, 8'h02, 8'h00);
		ev(3);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 1'b0);
		rd(RXC_STAT_ADDR, 8'h03, 8'h02);
		rd(RXC_STAT_ADDR, 8'h03, 8'h00);
		rd(RXC_CTRL_ADDR, 8'hff, 8'h00);
		xm <= 1'b0;
	endtask
	// interleaved storage: each data byte is followed by its valid byte
	task t_vld();
		wr(RXC_CFG_ADDR, 8'h01);
		wr(RXC_CTRL_ADDR, 8'h80);
		ev(0);
		push(8'h5a);
		push(8'h3c);
		ev(1);
		rd(RXC_STAT_ADDR, 8'h38, 8'h08);
		rd(RXC_CTRL_ADDR, 8'hff, 8'h00);
		pop(8'h5a);
		pop(8'ha5);
		pop(8'h3c);
		pop(8'hc3);
	endtask
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_cfg();
		t_packet();
		t_over();
		t_buf();
		t_err();
		t_vld();
		stop_test();
	end
	// hang guard, far beyond the fewer than a thousand cycles the sequence needs
	initial
	begin
		repeat (30000) @(posedge clk_i);
		fails++;
		stop_test();
	end
endmodule
